// *** hdl/cssw_pkg.sv ***
// Constants, types and register map of the clock source switch.
// Assumes a 125 MHz mclk; oscillator activity arrives as mclk-wide ticks.
package cssw_pkg;
  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] OFS_OSC = 8'h00;
  localparam logic [7:0] OFS_TUNE = 8'h04;
  localparam logic [7:0] OFS_TCTL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  // ==========================================================
  // Field positions
  localparam int IDLE_BIT = 7;
  localparam int IFS_LSB = 4;
  localparam int PSD_BIT = 3;
  localparam int FIS_BIT = 2;
  localparam int LFSS_BIT = 7;
  localparam int MULT_BIT = 6;
  localparam int SCA_BIT = 6;
  localparam int SOE_BIT = 3;
  // ==========================================================
  // Reset values and encodings
  localparam logic [1:0] CSS_RST = 2'h0;
  localparam logic [2:0] IFS_RST = 3'h4;
  localparam logic [1:0] CSS_PRI = 2'h0;
  localparam logic [1:0] CSS_SEC = 2'h1;
  localparam logic [2:0] IFS_31K = 3'h0;
  localparam logic [3:0] PRI_INT_A = 4'h9;
  localparam logic [3:0] PRI_INT_B = 4'h8;
  // ==========================================================
  // Timing counts, in ticks of the oscillator concerned
  localparam logic [1:0] OLD_TICKS = 2'h2;
  localparam logic [1:0] NEW_TICKS = 2'h3;
  localparam int OST_TICKS = 1024;
  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    CSSW_SW_RUN = 2'b00,
    CSSW_SW_OLD = 2'b01,
    CSSW_SW_NEW = 2'b10
  } cssw_sw_e;
  typedef enum logic [1:0]
  {
    CSSW_PM_RUN = 2'b00,
    CSSW_PM_IDLE = 2'b01,
    CSSW_PM_SLEEP = 2'b10
  } cssw_pm_e;
  typedef struct packed
  {
    logic pri;
    logic sec;
    logic fast_int;
    logic slow_rc;
  } cssw_ticks_s;
endpackage : cssw_pkg

// *** hdl/cssw_switch.sv ***
// Clock source switch: selection, postscaler, glitch-free switching,
// status flags and halt behaviour, with an APB register slave.
// Assumes oscillator ticks are one-cycle pulses synchronous to mclk.
//
// How it works
// RQ1 - Select field: 1x internal, 01 secondary, 00 primary
// RQ2 - Any reset clears the source select field
// RQ3 - New source taken once transition pause ends
// RQ4 - Frequency field picks 8 MHz down to 31 kHz
// RQ5 - Reset returns frequency field to 1 MHz
// RQ6 - Frequency change acts at once on internal clock
// RQ7 - At 000, low-frequency bit picks divider or RC
// RQ8 - Slow RC always clocks watchdog and monitor
// RQ9 - Primary start-up flag shows start-up timer expired
// RQ10 - Fast internal flag shows 8 MHz source stable
// RQ11 - At most one of three source flags set
// RQ12 - Idle-on-halt bit picks idle or sleep
// RQ13 - Secondary select ignored unless secondary enabled
// RQ14 - Software starts secondary oscillator before selecting it
// RQ15 - Switch pauses two old plus three new ticks
// RQ16 - Start-up flag reset value follows switchover setting
// RQ17 - Primary configuration picks primary oscillator mode
// RQ18 - Secondary active flag shows secondary clocking device
// RQ19 - Multiplier only for internal primary at 111/110
// RQ20 - No device clock pulses during the pause
`timescale 1ns/10ps
module cssw_switch
#(
  parameter int OST_LEN = cssw_pkg::OST_TICKS
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cssw_pkg::cssw_ticks_s osc_tick,
  input wire logic fast_int_stable,
  input wire logic [3:0] primary_osc_config,
  input wire logic internal_external_switchover,
  input wire logic halt_req,
  input wire logic wake_req,
  output logic dev_clk_tick,
  output logic wdt_clk_tick,
  output logic multiplier_active,
  output logic [3:0] primary_mode,
  output logic cpu_clk_on,
  output logic periph_clk_on
);
  // ==========================================================
  // Decoding used more than once
  function automatic logic src_tick(input logic [1:0] sel,
    input cssw_pkg::cssw_ticks_s t, input logic blk);
    if (sel[1])
      return blk;
    else if (sel == cssw_pkg::CSS_SEC)
      return t.sec;
    else
      return t.pri;
  endfunction : src_tick

  function automatic logic [7:0] div_mask(input logic [2:0] ifs);
    logic [7:0] m;
    m = 8'hff;
    if (ifs != cssw_pkg::IFS_31K)
      m = 8'(8'hff >> (4'h1 + {1'b0, ifs})); // 111 gives 0: every tick
    return m;
  endfunction : div_mask

  // ==========================================================
  // Registers
  logic idle_on_halt_reg;
  logic [2:0] internal_freq_select_reg;
  logic [1:0] clock_source_select_reg;
  logic low_freq_source_select_reg;
  logic multiplier_enable_reg;
  logic secondary_osc_enable_reg;
  logic ost_done_reg;
  logic init_reg;
  logic [10:0] ost_cnt_reg;
  logic [7:0] post_cnt_reg;
  logic [1:0] active_src_reg;
  logic [1:0] target_src_reg;
  logic [1:0] tick_cnt_reg;
  cssw_pkg::cssw_sw_e sw_reg;
  cssw_pkg::cssw_pm_e pm_reg;
  logic [31:0] prdata_reg;
  logic err_reg;

  logic wr_en;
  logic mult_ok;
  logic blk_tick;
  logic old_tick;
  logic new_tick;
  logic primary_startup_done;
  logic fast_internal_stable;
  logic secondary_clock_active;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;
  assign prdata = prdata_reg;

  // Multiplier only in internal primary modes at the two top rates
  assign mult_ok = (primary_osc_config == cssw_pkg::PRI_INT_A ||
    primary_osc_config == cssw_pkg::PRI_INT_B) &&
    internal_freq_select_reg[2:1] == 2'b11; // RQ19

  // ==========================================================
  // Oscillator control word
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_on_halt_reg <= 1'b0;
      internal_freq_select_reg <= cssw_pkg::IFS_RST; // RQ5
      clock_source_select_reg <= cssw_pkg::CSS_RST; // RQ2
    end
    else if (wr_en && paddr == cssw_pkg::OFS_OSC)
    begin
      idle_on_halt_reg <= pwdata[cssw_pkg::IDLE_BIT];
      internal_freq_select_reg <= pwdata[cssw_pkg::IFS_LSB +: 3];
      // Secondary request dropped while its oscillator is off
      if (pwdata[1:0] != cssw_pkg::CSS_SEC || secondary_osc_enable_reg)
        clock_source_select_reg <= pwdata[1:0]; // RQ13
    end
  end

  // Tuning and timer control bits
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_freq_source_select_reg <= 1'b0;
      multiplier_enable_reg <= 1'b0;
      secondary_osc_enable_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      if (paddr == cssw_pkg::OFS_TUNE)
      begin
        low_freq_source_select_reg <= pwdata[cssw_pkg::LFSS_BIT];
        multiplier_enable_reg <= pwdata[cssw_pkg::MULT_BIT];
      end
      if (paddr == cssw_pkg::OFS_TCTL)
        secondary_osc_enable_reg <= pwdata[cssw_pkg::SOE_BIT];
    end
  end

  // ==========================================================
  // Start-up timer; its first value is caught one edge after release
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_reg <= 1'b1;
      ost_done_reg <= 1'b0;
      ost_cnt_reg <= 11'h000;
    end
    else
    begin
      init_reg <= 1'b0;
      if (init_reg)
        ost_done_reg <= !internal_external_switchover; // RQ16
      else if (osc_tick.pri && !ost_done_reg)
      begin
        if (ost_cnt_reg == 11'(OST_LEN - 1))
          ost_done_reg <= 1'b1; // RQ9
        else
          ost_cnt_reg <= ost_cnt_reg + 11'h001;
      end
    end
  end

  // ==========================================================
  // Postscaler: mask reads the live field, so a new rate acts at once
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      post_cnt_reg <= 8'h00;
    else if (osc_tick.fast_int)
      post_cnt_reg <= post_cnt_reg + 8'h01;
  end

  always_comb
  begin
    blk_tick = osc_tick.fast_int &&
      (post_cnt_reg & div_mask(internal_freq_select_reg)) ==
      div_mask(internal_freq_select_reg); // RQ4 RQ6
    if (internal_freq_select_reg == cssw_pkg::IFS_31K &&
      !low_freq_source_select_reg)
      blk_tick = osc_tick.slow_rc; // RQ7
  end

  assign old_tick = src_tick(active_src_reg, osc_tick, blk_tick);
  assign new_tick = src_tick(target_src_reg, osc_tick, blk_tick);

  // ==========================================================
  // Switch sequencer: two old ticks, then three new ticks, then run
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_reg <= cssw_pkg::CSSW_SW_RUN;
      active_src_reg <= cssw_pkg::CSS_RST;
      target_src_reg <= cssw_pkg::CSS_RST;
      tick_cnt_reg <= 2'h0;
    end
    else
    begin
      case (sw_reg)
        cssw_pkg::CSSW_SW_RUN:
          if (clock_source_select_reg != active_src_reg)
          begin
            target_src_reg <= clock_source_select_reg;
            tick_cnt_reg <= 2'h0;
            sw_reg <= cssw_pkg::CSSW_SW_OLD; // RQ15
          end
        cssw_pkg::CSSW_SW_OLD:
          if (old_tick)
          begin
            if (tick_cnt_reg == cssw_pkg::OLD_TICKS - 2'h1)
            begin
              tick_cnt_reg <= 2'h0;
              sw_reg <= cssw_pkg::CSSW_SW_NEW;
            end
            else
              tick_cnt_reg <= tick_cnt_reg + 2'h1;
          end
        cssw_pkg::CSSW_SW_NEW:
          if (new_tick)
          begin
            if (tick_cnt_reg == cssw_pkg::NEW_TICKS - 2'h1)
            begin
              active_src_reg <= target_src_reg; // RQ1 RQ3
              sw_reg <= cssw_pkg::CSSW_SW_RUN;
            end
            else
              tick_cnt_reg <= tick_cnt_reg + 2'h1;
          end
        default:
          sw_reg <= cssw_pkg::CSSW_SW_RUN;
      endcase
    end
  end

  // ==========================================================
  // Halt picks idle or sleep; a wake request returns to run
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pm_reg <= cssw_pkg::CSSW_PM_RUN;
    else if (wake_req)
      pm_reg <= cssw_pkg::CSSW_PM_RUN;
    else if (halt_req && pm_reg == cssw_pkg::CSSW_PM_RUN)
      pm_reg <= idle_on_halt_reg ? cssw_pkg::CSSW_PM_IDLE :
        cssw_pkg::CSSW_PM_SLEEP; // RQ12
  end

  // ==========================================================
  // Clock outputs are registered ticks; the device tick is held low through any pause
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_clk_tick <= 1'b0;
      wdt_clk_tick <= 1'b0;
      multiplier_active <= 1'b0;
      primary_mode <= 4'h0;
    end
    else
    begin
      dev_clk_tick <= sw_reg == cssw_pkg::CSSW_SW_RUN && old_tick &&
        pm_reg != cssw_pkg::CSSW_PM_SLEEP; // RQ20
      wdt_clk_tick <= osc_tick.slow_rc; // RQ8
      multiplier_active <= mult_ok && multiplier_enable_reg &&
        active_src_reg[1] == 1'b0; // RQ19
      primary_mode <= (active_src_reg == cssw_pkg::CSS_PRI) ?
        primary_osc_config : 4'h0; // RQ17
    end
  end

  assign cpu_clk_on = pm_reg == cssw_pkg::CSSW_PM_RUN;
  assign periph_clk_on = pm_reg != cssw_pkg::CSSW_PM_SLEEP;

  // ==========================================================
  // Status flags are decoded from one source, so only one can be set
  assign primary_startup_done = ost_done_reg &&
    active_src_reg == cssw_pkg::CSS_PRI; // RQ9 RQ11
  assign fast_internal_stable = fast_int_stable && active_src_reg[1] &&
    !(internal_freq_select_reg == cssw_pkg::IFS_31K &&
    !low_freq_source_select_reg); // RQ10 RQ11
  assign secondary_clock_active =
    active_src_reg == cssw_pkg::CSS_SEC; // RQ18

  // Read mux; sampled in the setup cycle, shown in the access cycle
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      cssw_pkg::OFS_OSC:
        rd_word[7:0] = {idle_on_halt_reg, internal_freq_select_reg,
          primary_startup_done, fast_internal_stable,
          clock_source_select_reg};
      cssw_pkg::OFS_TUNE:
      begin
        rd_word[cssw_pkg::LFSS_BIT] = low_freq_source_select_reg;
        rd_word[cssw_pkg::MULT_BIT] = multiplier_enable_reg & mult_ok;
      end
      cssw_pkg::OFS_TCTL:
      begin
        rd_word[cssw_pkg::SCA_BIT] = secondary_clock_active; // RQ18
        rd_word[cssw_pkg::SOE_BIT] = secondary_osc_enable_reg;
      end
      cssw_pkg::OFS_STAT:
        rd_word[5:0] = {sw_reg, active_src_reg, pm_reg};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_reg <= rd_word;
      err_reg <= !rd_hit;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_sec_ignored: assert property ( // RQ13
    wr_en && paddr == cssw_pkg::OFS_OSC && pwdata[1:0] == 2'b01 &&
    !secondary_osc_enable_reg |=> $stable(clock_source_select_reg))
    else $error("secondary select taken while disabled");
  chk_no_pause_tick: assert property ( // RQ20
    sw_reg != cssw_pkg::CSSW_SW_RUN |=> !dev_clk_tick)
    else $error("clock tick during switch pause");
  chk_flags_onehot: assert property ( // RQ11
    $onehot0({primary_startup_done, fast_internal_stable,
    secondary_clock_active}))
    else $error("more than one source flag set");
  chk_wdt_rc_tick: assert property ( // RQ8
    osc_tick.slow_rc |=> wdt_clk_tick)
    else $error("watchdog tick missing");
  chk_mult_gate: assert property ( // RQ19
    multiplier_active |-> $past(internal_freq_select_reg[2:1]) == 2'b11)
    else $error("multiplier active at wrong rate");
  chk_halt_idle: assert property ( // RQ12
    halt_req && !wake_req && idle_on_halt_reg &&
    pm_reg == cssw_pkg::CSSW_PM_RUN |=> pm_reg == cssw_pkg::CSSW_PM_IDLE)
    else $error("halt did not enter idle");
  chk_fast_rate: assert property ( // RQ6
    sw_reg == cssw_pkg::CSSW_SW_RUN && active_src_reg[1] &&
    internal_freq_select_reg == 3'h7 && osc_tick.fast_int &&
    pm_reg != cssw_pkg::CSSW_PM_SLEEP |=> dev_clk_tick)
    else $error("8 MHz tick not passed");
  chk_switch_done: assert property ( // RQ3
    sw_reg == cssw_pkg::CSSW_SW_NEW && new_tick && tick_cnt_reg == 2'h2
    |=> active_src_reg == $past(target_src_reg) &&
    sw_reg == cssw_pkg::CSSW_SW_RUN)
    else $error("switch did not complete");
  chk_switch_start: assert property ( // RQ15
    sw_reg == cssw_pkg::CSSW_SW_RUN &&
    clock_source_select_reg != active_src_reg
    |=> sw_reg == cssw_pkg::CSSW_SW_OLD ##1 !dev_clk_tick)
    else $error("switch pause not entered");

  cov_switch_sec: cover property (
    sw_reg == cssw_pkg::CSSW_SW_NEW && target_src_reg == 2'h1 ##1
    sw_reg == cssw_pkg::CSSW_SW_RUN);
  cov_sleep: cover property (pm_reg == cssw_pkg::CSSW_PM_SLEEP);
  cov_mult: cover property (multiplier_active);
endmodule : cssw_switch

// *** tb/cssw_switch_tb.sv ***
// Self-checking bench for the clock source switch, driven over APB.
// Assumes one mclk domain and oscillator ticks made here as mclk pulses.
`timescale 1ns/10ps
module cssw_switch_tb;
  // ==========================================================
  // Signals
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cyc;
  cssw_pkg::cssw_ticks_s osc_tick;
  logic fast_int_stable, sw_over, halt_req, wake_req, er;
  logic [3:0] pcfg, primary_mode;
  logic dev_clk_tick, wdt_clk_tick, multiplier_active;
  logic cpu_clk_on, periph_clk_on;
  int err_count, cmp_count, nd, nw, ns, ni, pk;

  // ==========================================================
  // Design, start-up count shortened to keep the run brief
  cssw_switch #(.OST_LEN(8)) dut_u
  (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
    .fast_int_stable(fast_int_stable), .primary_osc_config(pcfg),
    .internal_external_switchover(sw_over), .halt_req(halt_req),
    .wake_req(wake_req), .dev_clk_tick(dev_clk_tick),
    .wdt_clk_tick(wdt_clk_tick), .multiplier_active(multiplier_active),
    .primary_mode(primary_mode), .cpu_clk_on(cpu_clk_on),
    .periph_clk_on(periph_clk_on)
  );

  // Clock at 125 MHz
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Oscillator ticks: primary /4, secondary /6, fast /2, slow RC /8
  // Periods divide the count windows so tallies do not hang on phase
  always @(posedge mclk)
  begin
    cyc <= cyc + 32'h1;
    osc_tick.pri <= (cyc[1:0] == 2'h3);
    osc_tick.sec <= (cyc % 6 == 5);
    osc_tick.fast_int <= cyc[0];
    osc_tick.slow_rc <= (cyc[2:0] == 3'h7);
  end

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      end_of_test();
    end
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
    input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  // Tally device and watchdog ticks over a window
  task automatic count(input int c);
    nd = 0;
    nw = 0;
    repeat (c)
    begin
      @(posedge mclk);
      nd += int'(dev_clk_tick === 1'b1);
      nw += int'(wdt_clk_tick === 1'b1);
    end
  endtask : count

  // Poll status until the switch settles on source s, bounded
  task automatic wait_src(input logic [1:0] s);
    int k;
    for (k = 0; k < 200; k++)
    begin
      apb(1'b0, 8'h0c, 32'h0);
      if (rd[5:2] === {2'h0, s})
        break;
    end
    chk("status", {28'h0, s, 2'h0}, rd);
    // A switch that never settles ends the run here
    if (k >= 200)
    begin
      err_count++;
      end_of_test();
    end
  endtask : wait_src

  task automatic pulse(input logic wk);
    if (wk)
      wake_req <= 1'b1;
    else
      halt_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    halt_req <= 1'b0;
    count(2);
  endtask : pulse

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, halt_req, wake_req} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc = 32'h0;
    osc_tick = '0;
    fast_int_stable = 1'b1;
    sw_over = 1'b1;
    pcfg = 4'h9;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(8'h00, 32'h40, "osc");
    count(64);
    rdchk(8'h00, 32'h48, "osc");
    chk("pmode", 32'h9, {28'h0, primary_mode});
    rdchk(8'h10, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, er});
    $display("test reset done");
    // Secondary refused while its oscillator is off, then taken
    apb(1'b1, 8'h00, 32'h41);
    rdchk(8'h00, 32'h48, "osc");
    apb(1'b1, 8'h08, 32'h08);
    apb(1'b1, 8'h00, 32'h41);
    wait_src(2'h1);
    chk("pmode", 32'h0, {28'h0, primary_mode});
    rdchk(8'h08, 32'h48, "tctl");
    rdchk(8'h00, 32'h41, "osc");
    $display("test secondary done");
    // Pause: two old then three new ticks with no device tick
    apb(1'b1, 8'h00, 32'h72);
    ns = 0;
    ni = 0;
    for (pk = 0; pk < 200; pk++)
    begin
      @(posedge mclk);
      if (pk >= 2 && dev_clk_tick === 1'b1)
        break;
      if (osc_tick.sec)
        ns++;
      else if (ns >= 2 && osc_tick.fast_int)
        ni++;
    end
    chk("pause", 32'h1, {31'h0, ns >= 2 && ni >= 3 && ni <= 5});
    // No device tick at all within the bound ends the run
    if (pk >= 200)
    begin
      err_count++;
      end_of_test();
    end
    wait_src(2'h2);
    rdchk(8'h00, 32'h76, "osc");
    fast_int_stable <= 1'b0;
    rdchk(8'h00, 32'h72, "osc");
    fast_int_stable <= 1'b1;
    $display("test internal done");
    // Postscaler rates, changed on the fly
    for (int f = 7; f >= 0; f--)
    begin
      apb(1'b1, 8'h00, {24'h0, 1'b0, 3'(f), 4'h2});
      count(128);
      count(512);
      chk("rate", (f == 0) ? 64 : (256 >> (7 - f)), nd);
    end
    apb(1'b1, 8'h04, 32'h80);
    count(128);
    count(512);
    chk("rate", 32'h1, nd);
    chk("wdt", 32'd64, nw);
    $display("test rates done");
    // Multiplier only on primary internal at high settings
    apb(1'b1, 8'h00, 32'h70);
    wait_src(2'h0);
    apb(1'b1, 8'h04, 32'h40);
    count(4);
    chk("mult", 32'h1, {31'h0, multiplier_active});
    rdchk(8'h04, 32'h40, "tune");
    // A non-internal primary mode must block the multiplier
    pcfg <= 4'h2;
    count(4);
    chk("mult", 32'h0, {31'h0, multiplier_active});
    rdchk(8'h04, 32'h0, "tune");
    pcfg <= 4'h8;
    count(4);
    chk("mult", 32'h1, {31'h0, multiplier_active});
    apb(1'b1, 8'h00, 32'h40);
    count(4);
    chk("mult", 32'h0, {31'h0, multiplier_active});
    rdchk(8'h04, 32'h0, "tune");
    $display("test multiplier done");
    // Halt into idle, then into sleep
    apb(1'b1, 8'h00, 32'hc0);
    pulse(1'b0);
    chk("clk_on", 32'h1, {30'h0, cpu_clk_on, periph_clk_on});
    rdchk(8'h0c, 32'h1, "status");
    pulse(1'b1);
    apb(1'b1, 8'h00, 32'h40);
    pulse(1'b0);
    chk("clk_on", 32'h0, {30'h0, cpu_clk_on, periph_clk_on});
    count(64);
    chk("sleep", 32'h0, nd);
    pulse(1'b1);
    $display("test halt done");
    // Reset in mid-run with the other switchover setting
    rst_n <= 1'b0;
    sw_over <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    count(2);
    rdchk(8'h00, 32'h48, "osc");
    $display("test second reset done");
    end_of_test();
  end
endmodule : cssw_switch_tb
